/* hdl/sigpc_top.sv */
// signature read and power-up control of the serial flash core
//
// Summary of operation
// RULE1: deep power-down ignores all but wake commands
// RULE2: signature or release command leaves deep power-down
// RULE3: host sends code plus three dummy bytes
// RULE4: input bits captured on rising link clock
// RULE5: signature shifted out on falling link edges
// RULE6: early deselect after code still reaches standby
// RULE7: no signature during running write cycles
// RULE8: signature available outside deep power-down too
// RULE9: continued clocking repeats the signature byte
// RULE10: deselect gives standby at once normally
// RULE11: unread wake from power-down waits first delay
// RULE12: read wake from power-down waits second delay
// RULE13: reset holds all logic, no answers
// RULE14: write-type commands dropped during power-up delay
// RULE15: host stays deselected until supply settles
// RULE16: reads accepted while write delay still runs
// RULE17: host defers writes until both delays pass
// RULE18: reset leaves standby with both flags clear
// RULE19: supply loss disables all operations
// RULE20: only power-down command enters deep power-down
// RULE21: dummy byte values are ignored
`timescale 1ns/1ps
module sigpc_top
#(
   parameter int         INHIBIT_CYCLES = sigpc_pkg::INHIBIT_CYCLES,
   parameter logic [7:0] SIGNATURE      = sigpc_pkg::SIGNATURE_DEFAULT
)
(
   // clock and power-on reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // serial link
   input  wire logic       sclk,
   input  wire logic       selectN,
   input  wire logic       serialIn,
   output logic            serialOut,
   output logic            serialOutEn,
   // write engine of the device
   input  wire logic       cycleStart,
   input  wire logic       cycleDone,
   input  wire logic       latchClear,
   // commands handed on and status
   output logic            cmdAccept,
   output logic [7:0]      cmdCode,
   output logic            writeLatchFlag,
   output logic            writeCycleActive,
   output logic            writeInhibit,
   output logic            deepPowerDown,
   output logic            standby
);

   localparam int INH_W = $clog2(INHIBIT_CYCLES + 1);
   localparam logic [INH_W-1:0] INH_LAST = INH_W'(INHIBIT_CYCLES);
   localparam logic [8:0] WAKE_UNREAD_LOAD =
      9'(sigpc_pkg::WAKE_UNREAD_CYCLES - 1);
   localparam logic [8:0] WAKE_READ_LOAD =
      9'(sigpc_pkg::WAKE_READ_CYCLES - 1);
   localparam logic [8:0] WAKE_UNREAD_LEN = 9'(sigpc_pkg::WAKE_UNREAD_CYCLES);
   localparam logic [8:0] WAKE_READ_LEN = 9'(sigpc_pkg::WAKE_READ_CYCLES);

   generate
      if (INHIBIT_CYCLES < 1)
         $error("write inhibit count must be at least one cycle");
      if (sigpc_pkg::WAKE_UNREAD_CYCLES < 1 ||
          sigpc_pkg::WAKE_UNREAD_CYCLES > 512)
         $error("wake delay does not fit the wake counter");
   endgenerate

   // -----------------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------------
   sigpc_pkg::sigpc_state_type state;
   sigpc_pkg::sigpc_state_type next_state;
   sigpc_pkg::sigpc_link_type  linkInfo;
   logic             selSync;
   logic             selPrev;
   logic [2:0]       graySync;
   logic [2:0]       evSeen;
   logic [2:0]       frameBytes;
   logic [7:0]       cmdLatched;
   logic [INH_W-1:0] inhibitCnt;
   logic [8:0]       wakeCnt;
   logic [8:0]       next_wakeCnt;
   logic             sigAllow;

   // -----------------------------------------------------------------------
   // link end and crossings
   // -----------------------------------------------------------------------
   sigpc_link
   #(
      .SIGNATURE (SIGNATURE)
   )
   u_link
   (
      .sclk        (sclk),
      .selectN     (selectN),
      .serialIn    (serialIn),
      .serialOut   (serialOut),
      .serialOutEn (serialOutEn),
      .rst_n       (rst_n),
      .sigAllow    (sigAllow),
      .linkInfo    (linkInfo)
   );

   sigpc_sync
   #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   )
   u_sel_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (selectN),
      .q     (selSync)
   );

   // byte events cross as a gray count, one step at a time
   sigpc_sync
   #(
      .WIDTH     (3),
      .RESET_VAL (3'h0)
   )
   u_gray_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (linkInfo.byteGray),
      .q     (graySync)
   );

   // -----------------------------------------------------------------------
   // frame decode
   // -----------------------------------------------------------------------
   wire frameStart = selPrev & ~selSync;
   wire frameEnd   = ~selPrev & selSync;
   wire byteEvent  = sigpc_pkg::gray2bin(graySync) != evSeen;
   wire hasCmd     = frameBytes != 3'h0;
   wire isSig      = hasCmd && cmdLatched == sigpc_pkg::CMD_SIG;
   wire isDeep     = hasCmd && cmdLatched == sigpc_pkg::CMD_DP;
   wire isWren     = hasCmd && cmdLatched == sigpc_pkg::CMD_WREN;
   wire isWrdi     = hasCmd && cmdLatched == sigpc_pkg::CMD_WRDI;
   wire isWriteType = hasCmd &&
                     (cmdLatched == sigpc_pkg::CMD_WREN ||
                      cmdLatched == sigpc_pkg::CMD_PP   ||
                      cmdLatched == sigpc_pkg::CMD_SE   ||
                      cmdLatched == sigpc_pkg::CMD_BE   ||
                      cmdLatched == sigpc_pkg::CMD_WRSR);
   wire sigRead    = frameBytes >= sigpc_pkg::SIG_READ_BYTES;
   wire inStandby  = state == sigpc_pkg::ST_STANDBY;
   wire inDeep     = state == sigpc_pkg::ST_DEEP;
   wire inWake     = state == sigpc_pkg::ST_WAKE;
   wire wakeDone   = inWake && wakeCnt == 9'h000;

   // commands passed on at deselect; reads need no wait for the timer
   wire handOn     = frameEnd && inStandby && hasCmd && !isSig && // RULE16
                     !isDeep && !(isWriteType && writeInhibit); // RULE14
   wire enterDeep  = frameEnd && inStandby && isDeep && // RULE20
                     !writeCycleActive;
   wire leaveDeep  = frameEnd && inDeep && isSig; // RULE2
   wire setLatch   = handOn && isWren;
   wire clrLatch   = (handOn && isWrdi) || latchClear;

   // signature refused while a write cycle runs or the wake delay is on
   assign sigAllow = !writeCycleActive && !inWake; // RULE7 RULE8

   // -----------------------------------------------------------------------
   // frame tracking
   // -----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         selPrev    <= 1'b1;
         evSeen     <= 3'h0;
         frameBytes <= 3'h0;
         cmdLatched <= 8'h00;
      end
      else
      begin
         selPrev <= selSync;
         if (byteEvent)
            evSeen <= evSeen + 3'h1;
         if (frameStart)
            frameBytes <= 3'h0;
         else if (byteEvent && frameBytes != sigpc_pkg::BYTE_CNT_MAX)
            frameBytes <= frameBytes + 3'h1;
         // the link holds the code stable until the next frame's first byte
         if (byteEvent && frameBytes == 3'h0 && !frameStart)
            cmdLatched <= linkInfo.cmd;
      end
   end

   // -----------------------------------------------------------------------
   // power mode state machine
   // -----------------------------------------------------------------------
   always_comb
   begin
      next_state   = state;
      next_wakeCnt = wakeCnt;
      case (state)
         sigpc_pkg::ST_STANDBY:
         begin
            if (enterDeep)
               next_state = sigpc_pkg::ST_DEEP;
         end
         sigpc_pkg::ST_DEEP:
         begin
            // every other code is dropped here
            if (leaveDeep) // RULE1
            begin
               next_state   = sigpc_pkg::ST_WAKE;
               next_wakeCnt = sigRead ? WAKE_READ_LOAD // RULE12
                                      : WAKE_UNREAD_LOAD; // RULE11
            end
         end
         sigpc_pkg::ST_WAKE:
         begin
            if (wakeDone)
               next_state = sigpc_pkg::ST_STANDBY;
            else
               next_wakeCnt = wakeCnt - 9'h001;
         end
         default:
            next_state = sigpc_pkg::ST_STANDBY;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state   <= sigpc_pkg::ST_STANDBY; // RULE18
         wakeCnt <= 9'h000;
      end
      else
      begin
         state   <= next_state;
         wakeCnt <= next_wakeCnt;
      end
   end

   // -----------------------------------------------------------------------
   // power-up write inhibit and flags
   // -----------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         // low supply holds everything here and answers nothing
         inhibitCnt       <= '0; // RULE13 RULE19
         writeInhibit     <= 1'b1;
         writeLatchFlag   <= 1'b0; // RULE18
         writeCycleActive <= 1'b0;
         cmdAccept        <= 1'b0;
         cmdCode          <= 8'h00;
      end
      else
      begin
         if (inhibitCnt != INH_LAST)
            inhibitCnt <= inhibitCnt + INH_W'(1);
         writeInhibit <= (inhibitCnt != INH_LAST) &&
                         (inhibitCnt != INH_LAST - INH_W'(1)); // RULE14
         // a set arriving with a clear wins
         if (setLatch)
            writeLatchFlag <= 1'b1;
         else if (clrLatch)
            writeLatchFlag <= 1'b0;
         if (cycleStart)
            writeCycleActive <= 1'b1;
         else if (cycleDone)
            writeCycleActive <= 1'b0;
         cmdAccept <= handOn;
         if (handOn)
            cmdCode <= cmdLatched;
      end
   end

   assign deepPowerDown = state[1];
   // a signature frame ends in standby at once unless it woke the device or a write cycle runs
   assign standby = state[0] && !writeCycleActive; // RULE6 RULE10

   // checker helper: wake length counted apart from the wake counter
   logic [8:0] wakeSeen;
   logic       wakeFromRead;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wakeSeen     <= 9'h000;
         wakeFromRead <= 1'b0;
      end
      else if (leaveDeep)
      begin
         wakeSeen     <= 9'h000;
         wakeFromRead <= sigRead;
      end
      else if (inWake)
         wakeSeen <= wakeSeen + 9'h001;
   end

   // -----------------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------------
   a_deep_ignores_other: assert property ( // RULE1
      @(posedge clk) disable iff (!rst_n)
      inDeep && frameEnd && !isSig |=> inDeep && !cmdAccept)
      else $error("command obeyed in deep power-down");

   a_sig_leaves_deep: assert property ( // RULE2
      @(posedge clk) disable iff (!rst_n)
      inDeep && frameEnd && isSig |=> inWake)
      else $error("signature did not leave deep power-down");

   a_wake_unread_len: assert property ( // RULE11
      @(posedge clk) disable iff (!rst_n)
      $fell(inWake) && !wakeFromRead
      |-> inStandby && wakeSeen == WAKE_UNREAD_LEN)
      else $error("unread wake delay wrong");

   a_wake_read_len: assert property ( // RULE12
      @(posedge clk) disable iff (!rst_n)
      $fell(inWake) && wakeFromRead
      |-> inStandby && wakeSeen == WAKE_READ_LEN)
      else $error("read wake delay wrong");

   a_busy_no_sig: assert property ( // RULE7
      @(posedge clk) disable iff (!rst_n)
      writeCycleActive |-> !sigAllow)
      else $error("signature allowed during write cycle");

   a_sig_standby_now: assert property ( // RULE10
      @(posedge clk) disable iff (!rst_n)
      inStandby && frameEnd && isSig && !writeCycleActive
      |=> standby && !cmdAccept && !deepPowerDown)
      else $error("signature frame left standby");

   a_inhibit_drops: assert property ( // RULE14
      @(posedge clk) disable iff (!rst_n)
      frameEnd && inStandby && isWriteType && writeInhibit
      |=> !cmdAccept && $stable(writeLatchFlag))
      else $error("write command taken during power-up delay");

   a_read_early_ok: assert property ( // RULE16
      @(posedge clk) disable iff (!rst_n)
      frameEnd && inStandby && hasCmd && !isWriteType && !isSig &&
      !isDeep |=> cmdAccept && cmdCode == $past(cmdLatched))
      else $error("read command not handed on");

   a_reset_state: assert property ( // RULE18
      @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> inStandby && !writeLatchFlag &&
      !writeCycleActive && writeInhibit)
      else $error("state after reset wrong");

   a_deep_entry: assert property ( // RULE20
      @(posedge clk) disable iff (!rst_n)
      !inDeep ##1 inDeep |-> $past(frameEnd && isDeep && !writeCycleActive))
      else $error("deep power-down entered without its command");

endmodule

/* inc/sigpc_pkg.sv */
// constants, types and helpers shared by the signature and power-up control
package sigpc_pkg;

   // -----------------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 8;
   // least time before write-type commands are honoured, 1.0 ms
   localparam int INHIBIT_DELAY_US = 1000;
   localparam int INHIBIT_CYCLES   =
      (INHIBIT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // wake delays out of deep power-down, longest figures, rounded down
   localparam int WAKE_UNREAD_NS   = 3000;
   localparam int WAKE_READ_NS     = 1800;
   localparam int WAKE_UNREAD_CYCLES = WAKE_UNREAD_NS / CLK_PERIOD_NS;
   localparam int WAKE_READ_CYCLES   = WAKE_READ_NS / CLK_PERIOD_NS;
   localparam int WAKE_CNT_W       = 9;

   // -----------------------------------------------------------------------
   // frame layout
   // -----------------------------------------------------------------------
   localparam logic [2:0] SIG_START_BYTE = 3'h4;
   localparam logic [2:0] SIG_READ_BYTES = 3'h5;
   localparam logic [2:0] BYTE_CNT_MAX   = 3'h5;

   // -----------------------------------------------------------------------
   // command codes
   // -----------------------------------------------------------------------
   localparam logic [7:0] CMD_SIG  = 8'hAB;
   localparam logic [7:0] CMD_DP   = 8'hB9;
   localparam logic [7:0] CMD_WREN = 8'h06;
   localparam logic [7:0] CMD_WRDI = 8'h04;
   localparam logic [7:0] CMD_PP   = 8'h02;
   localparam logic [7:0] CMD_SE   = 8'hD8;
   localparam logic [7:0] CMD_BE   = 8'hC7;
   localparam logic [7:0] CMD_WRSR = 8'h01;
   // arbitrary signature value
   localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5A;

   // -----------------------------------------------------------------------
   // types
   // -----------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_STANDBY = 3'b001,
      ST_DEEP    = 3'b010,
      ST_WAKE    = 3'b100
   } sigpc_state_type;

   typedef struct packed
   {
      logic [7:0] cmd;
      logic [2:0] byteGray;
   } sigpc_link_type;

   function automatic logic [2:0] gray2bin(input logic [2:0] g);
      gray2bin = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
   endfunction

endpackage

/* hdl/sigpc_sync.sv */
// two flip-flop level synchroniser with synchronous reset
`timescale 1ns/1ps
module sigpc_sync
#(
   parameter int                 WIDTH     = 1,
   parameter logic [WIDTH-1:0]   RESET_VAL = '0
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // level in and out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta <= RESET_VAL;
         q    <= RESET_VAL;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

/* hdl/sigpc_link.sv */
// serial link end: bit capture on the link clock, signature shift-out
`timescale 1ns/1ps
module sigpc_link
#(
   parameter logic [7:0] SIGNATURE = sigpc_pkg::SIGNATURE_DEFAULT
)
(
   // serial pins
   input  wire logic             sclk,
   input  wire logic             selectN,
   input  wire logic             serialIn,
   output logic                  serialOut,
   output logic                  serialOutEn,
   // core side
   input  wire logic             rst_n,
   input  wire logic             sigAllow,
   output sigpc_pkg::sigpc_link_type linkInfo
);

   logic       frameClear;
   logic [2:0] bitCnt;
   logic [2:0] byteCnt;
   logic [2:0] evCount;
   logic [2:0] evGray;
   logic [6:0] shiftIn;
   logic [7:0] cmd;
   logic       allowMeta;
   logic       allowSync;
   wire        byteDone = (bitCnt == 3'h7);
   wire  [7:0] nextByte = {shiftIn, serialIn};
   wire  [2:0] nextEv   = evCount + 3'h1;
   // only the byte count matters for the dummy bytes, never their value
   wire        sending  = allowSync && (cmd == sigpc_pkg::CMD_SIG) &&
                          (byteCnt >= sigpc_pkg::SIG_START_BYTE); // RULE21

   // the link clock stops between frames, so the frame's own select ends it
   assign frameClear = selectN | ~rst_n;

   // -----------------------------------------------------------------------
   // capture on rising edges
   // -----------------------------------------------------------------------
   always_ff @(posedge sclk or posedge frameClear)
   begin
      if (frameClear)
      begin
         bitCnt  <= 3'h0;
         byteCnt <= 3'h0;
         shiftIn <= 7'h00;
      end
      else
      begin
         shiftIn <= nextByte[6:0]; // RULE4
         bitCnt  <= bitCnt + 3'h1;
         if (byteDone && byteCnt != sigpc_pkg::BYTE_CNT_MAX)
            byteCnt <= byteCnt + 3'h1;
      end
   end

   // event count and command survive the frame end for the core to read
   always_ff @(posedge sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evCount   <= 3'h0;
         evGray    <= 3'h0;
         cmd       <= 8'h00;
         allowMeta <= 1'b0;
         allowSync <= 1'b0;
      end
      else
      begin
         allowMeta <= sigAllow;
         allowSync <= allowMeta;
         // gray code kept in a flop so the crossing never sees a glitch
         if (byteDone)
         begin
            evCount <= nextEv;
            evGray  <= nextEv ^ (nextEv >> 1);
         end
         if (byteDone && byteCnt == 3'h0)
            cmd <= nextByte;
      end
   end

   // -----------------------------------------------------------------------
   // signature out on falling edges, repeated while clocks keep coming
   // -----------------------------------------------------------------------
   always_ff @(negedge sclk or posedge frameClear)
   begin
      if (frameClear)
      begin
         serialOut   <= 1'b0;
         serialOutEn <= 1'b0;
      end
      else
      begin
         serialOutEn <= sending; // RULE5
         serialOut   <= sending & SIGNATURE[~bitCnt]; // RULE9
      end
   end

   assign linkInfo = '{cmd: cmd, byteGray: evGray};

endmodule

/* tb/sigpc_host.sv */
// host model: drives frames on the serial link, link clock only in frames
`timescale 1ns/1ps
module sigpc_host
(
   // serial pins
   output logic      sclk,
   output logic      selectN,
   output logic      serialIn,
   input  wire logic serialOut,
   input  wire logic serialOutEn
);
   initial
   begin
      sclk     = 1'b0;
      selectN  = 1'b1;
      serialIn = 1'b0;
   end

   // -----------------------------------------------------------------------
   // one frame, MSB first; returns the last byte seen after the dummies
   // -----------------------------------------------------------------------
   task automatic frame(input logic [7:0] code, input logic [7:0] dummy,
      input int nb, output logic [7:0] got, output logic en);
      logic [7:0] b;
      got = 8'h00;
      en  = 1'b0;
      // idle gap keeps the deselect time and shifts the link phase
      #205;
      selectN = 1'b0;
      for (int i = 0; i < nb * 8; i++)
      begin
         b        = (i < 8) ? code : dummy;
         serialIn = b[7 - i % 8];
         #32 sclk = 1'b1;
         if (i >= 32)
         begin
            got = {got[6:0], serialOut};
            en  = en | serialOutEn;
         end
         #32 sclk = 1'b0;
      end
      #32 selectN = 1'b1;
      // released data line must not keep its last value
      serialIn = ~serialIn;
   endtask
endmodule

/* tb/sigpc_top_tb.sv */
// self-checking bench for the signature and power-up control
`timescale 1ns/1ps
module sigpc_top_tb;
   localparam int         INHIB = 1000;
   localparam logic [7:0] SIG   = sigpc_pkg::SIGNATURE_DEFAULT;

   typedef struct packed
   {
      logic [7:0] code;
      logic [7:0] dummy;
      logic [2:0] nb;
      logic       acc;
      logic       sig;
   } sigpc_row_type;

   logic       clk, rst_n, sclk, selectN, serialIn, serialOut;
   logic       serialOutEn, cycleStart, cycleDone, latchClear;
   logic       cmdAccept, writeLatchFlag, writeCycleActive;
   logic       writeInhibit, deepPowerDown, standby, en;
   logic [7:0] cmdCode, lastCode, got;
   int         miscompares = 0, nChecks = 0, nAcc = 0, cyc = 0;
   int         a0, n, relCyc;

   sigpc_row_type rows[9] = '{
      '{8'h03, 8'h00, 3'h4, 1'b1, 1'b0},
      '{sigpc_pkg::CMD_SIG, 8'hFF, 3'h5, 1'b0, 1'b1},
      '{sigpc_pkg::CMD_SIG, 8'h00, 3'h6, 1'b0, 1'b1},
      '{sigpc_pkg::CMD_PP, 8'h00, 3'h4, 1'b1, 1'b0},
      '{sigpc_pkg::CMD_SE, 8'h00, 3'h4, 1'b1, 1'b0},
      '{sigpc_pkg::CMD_BE, 8'h00, 3'h1, 1'b1, 1'b0},
      '{sigpc_pkg::CMD_WRSR, 8'h00, 3'h2, 1'b1, 1'b0},
      '{sigpc_pkg::CMD_WRDI, 8'h00, 3'h1, 1'b1, 1'b0},
      '{sigpc_pkg::CMD_WREN, 8'h00, 3'h1, 1'b1, 1'b0}};
   logic [7:0] wcode[5] = '{sigpc_pkg::CMD_WREN, sigpc_pkg::CMD_PP,
      sigpc_pkg::CMD_SE, sigpc_pkg::CMD_BE, sigpc_pkg::CMD_WRSR};

   sigpc_top #(.INHIBIT_CYCLES(INHIB)) u_sigpc_top
   (
      .clk(clk), .rst_n(rst_n), .sclk(sclk), .selectN(selectN),
      .serialIn(serialIn), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .cycleStart(cycleStart),
      .cycleDone(cycleDone), .latchClear(latchClear),
      .cmdAccept(cmdAccept), .cmdCode(cmdCode),
      .writeLatchFlag(writeLatchFlag),
      .writeCycleActive(writeCycleActive),
      .writeInhibit(writeInhibit), .deepPowerDown(deepPowerDown),
      .standby(standby)
   );

   sigpc_host u_sigpc_host
   (
      .sclk(sclk), .selectN(selectN), .serialIn(serialIn),
      .serialOut(serialOut), .serialOutEn(serialOutEn)
   );

   // -----------------------------------------------------------------------
   // clock, hand-on monitor, timeout
   // -----------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cmdAccept === 1'b1)
      begin
         nAcc     <= nAcc + 1;
         lastCode <= cmdCode;
      end
      if (cyc == 20000)
      begin
         miscompares++;
         end_sim;
      end
   end

   // -----------------------------------------------------------------------
   // compare and drive tasks
   // -----------------------------------------------------------------------
   task chk1(input logic act, input logic exp);
      nChecks++;
      if (act !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: bit %b not %b", $time, act, exp);
      end
   endtask

   task chk8(input logic [7:0] act, input logic [7:0] exp);
      nChecks++;
      if (act !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: byte %h not %h", $time, act, exp);
      end
   endtask

   task run(input logic [7:0] c, input logic [7:0] d, input int nb,
      input int w);
      a0 = nAcc;
      u_sigpc_host.frame(c, d, nb, got, en);
      repeat (w) @(negedge clk);
   endtask

   // host stays deselected until standby is back, bounded
   task wake(input int exp);
      n = 0;
      while (standby !== 1'b1 && n < 1000)
      begin
         @(negedge clk);
         n++;
      end
      chk1(logic'(n inside {[exp:exp + 10]}), 1'b1);
      chk1(deepPowerDown, 1'b0);
   endtask

   task end_sim;
      $display("checks %0d miscompares %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // -----------------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------------
   initial
   begin
      rst_n      = 1'b0;
      cycleStart = 1'b0;
      cycleDone  = 1'b0;
      latchClear = 1'b0;
      repeat (5) @(negedge clk);
      chk1(standby, 1'b1);
      chk1(deepPowerDown, 1'b0);
      chk1(writeLatchFlag, 1'b0);
      chk1(writeCycleActive, 1'b0);
      chk1(writeInhibit, 1'b1);
      rst_n  = 1'b1;
      relCyc = cyc;
      repeat (4) @(negedge clk);
      foreach (wcode[k])
      begin
         run(wcode[k], 8'h00, 1, 8);
         chk1(logic'(nAcc != a0), 1'b0);
      end
      chk1(writeLatchFlag, 1'b0);
      run(8'h03, 8'h00, 4, 8);
      chk1(logic'(nAcc != a0), 1'b1);
      chk1(writeInhibit, 1'b1);
      while (writeInhibit !== 1'b0 && cyc - relCyc < 2000)
         @(negedge clk);
      chk1(logic'((cyc - relCyc) inside {[INHIB-3:INHIB+4]}), 1'b1);
      foreach (rows[k])
      begin
         run(rows[k].code, rows[k].dummy, int'(rows[k].nb), 8);
         chk1(logic'(nAcc != a0), rows[k].acc);
         chk1(en, rows[k].sig);
         if (rows[k].sig)
            chk8(got, SIG);
         if (rows[k].acc)
            chk8(lastCode, rows[k].code);
      end
      chk1(writeLatchFlag, 1'b1);
      latchClear = 1'b1;
      @(negedge clk);
      latchClear = 1'b0;
      @(negedge clk);
      chk1(writeLatchFlag, 1'b0);
      run(sigpc_pkg::CMD_SIG, 8'h00, 2, 8);
      chk1(standby, 1'b1);
      cycleStart = 1'b1;
      @(negedge clk);
      cycleStart = 1'b0;
      run(sigpc_pkg::CMD_SIG, 8'h00, 5, 8);
      chk1(en, 1'b0);
      chk1(writeCycleActive, 1'b1);
      cycleDone = 1'b1;
      @(negedge clk);
      cycleDone = 1'b0;
      @(negedge clk);
      chk1(standby, 1'b1);
      run(sigpc_pkg::CMD_DP, 8'h00, 1, 8);
      chk1(deepPowerDown, 1'b1);
      run(8'h03, 8'h00, 4, 8);
      chk1(logic'(nAcc != a0), 1'b0);
      run(sigpc_pkg::CMD_SIG, 8'h00, 1, 0);
      wake(sigpc_pkg::WAKE_UNREAD_CYCLES);
      run(sigpc_pkg::CMD_DP, 8'h00, 1, 8);
      run(sigpc_pkg::CMD_SIG, 8'h3C, 5, 0);
      chk8(got, SIG);
      wake(sigpc_pkg::WAKE_READ_CYCLES);
      run(sigpc_pkg::CMD_DP, 8'h00, 1, 8);
      rst_n = 1'b0;
      run(8'h03, 8'h00, 4, 8);
      chk1(logic'(nAcc != a0), 1'b0);
      chk1(deepPowerDown, 1'b0);
      chk1(standby, 1'b1);
      rst_n = 1'b1;
      // the inhibit timer starts over from the second release
      repeat (3) @(negedge clk);
      chk1(writeInhibit, 1'b1);
      chk1(standby, 1'b1);
      end_sim;
   end
endmodule
